/* File: hdl/dscp_map_pkg.sv */
/*
  Constants and carrier types for the upper DSCP priority map.
  Assumes a 32-bit Avalon-MM slave with byte addresses and one clock.
*/
package dscp_map_pkg;
  localparam int MAP_ENTRIES = 12;
  localparam int MAP_IDX_W   = 4;
  localparam int PRI_W       = 3;
  localparam int ENTRY_W     = 2 * PRI_W;
  localparam int BUS_ADDR_W  = 12;

  // field positions inside one mapping byte
  localparam int PRI_ODD_LSB  = 4;
  localparam int PRI_EVEN_LSB = 0;
  localparam int RESV_HI_BIT  = 7;
  localparam int RESV_LO_BIT  = 3;
  localparam logic [7:0] MAP_RESET = 8'h00;

  // code points covered here
  localparam logic [5:0] CP_FIRST = 6'h26;
  localparam logic [5:0] CP_LAST  = 6'h3d;

  // register indices; byte address is four times the index
  localparam logic [9:0] OFS_MAP_26_27 = 10'h353;
  localparam logic [9:0] OFS_MAP_28_29 = 10'h354;
  localparam logic [9:0] OFS_MAP_2A_2B = 10'h355;
  localparam logic [9:0] OFS_MAP_2C_2D = 10'h350;
  localparam logic [9:0] OFS_MAP_2C_2D_SEQ = 10'h356;
  localparam logic [9:0] OFS_MAP_2E_2F = 10'h357;
  localparam logic [9:0] OFS_MAP_30_31 = 10'h358;
  localparam logic [9:0] OFS_MAP_32_33 = 10'h359;
  localparam logic [9:0] OFS_MAP_34_35 = 10'h35a;
  localparam logic [9:0] OFS_MAP_36_37 = 10'h35b;
  localparam logic [9:0] OFS_MAP_38_39 = 10'h35c;
  localparam logic [9:0] OFS_MAP_3A_3B = 10'h35d;
  localparam logic [9:0] OFS_MAP_3C_3D = 10'h35e;

  typedef struct packed {
    logic [PRI_W-1:0] odd_pri;
    logic [PRI_W-1:0] even_pri;
  } map_entry_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] dscp;
  } lookup_req_s;

  typedef struct packed {
    logic             valid;
    logic             hit;
    logic [PRI_W-1:0] pri;
  } lookup_rsp_s;

  typedef struct packed {
    logic                 hit;
    logic [MAP_IDX_W-1:0] idx;
  } reg_decode_s;

  typedef enum logic [2:0] {
    BUS_IDLE   = 3'h1,
    BUS_FETCH  = 3'h2,
    BUS_ANSWER = 3'h4
  } bus_state_e;
endpackage

/* File: hdl/pri_map_mem.sv */
/*
  Storage of the mapping entries with one write port and two
  registered read ports (software and frame lookup).
  Assumes the owner keeps indices in range and a synchronous reset.
*/
`timescale 1ns/100ps
module pri_map_mem
  import dscp_map_pkg::*;
#(
  parameter int ENTRIES = MAP_ENTRIES,
  parameter int IDX_W   = MAP_IDX_W
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       wr_en,
  input  wire logic [IDX_W-1:0]           wr_idx,
  input  wire map_entry_s                 wr_data,
  input  wire logic [IDX_W-1:0]           bus_idx,
  output map_entry_s                      bus_data,
  input  wire logic [IDX_W-1:0]           lu_idx,
  output map_entry_s                      lu_data,
  output logic [ENTRIES*ENTRY_W-1:0]      table_flat
);
  map_entry_s store [ENTRIES];

  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        store[i] <= map_entry_s'(ENTRY_W'(MAP_RESET));
      end else if (wr_en && wr_idx == IDX_W'(i)) begin
        store[i] <= wr_data;
      end
    end
    assign table_flat[i*ENTRY_W +: ENTRY_W] = store[i];
  end

  // out-of-range reads give zero rather than an x
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_data <= '0;
    end else if (int'(bus_idx) < ENTRIES) begin
      bus_data <= store[bus_idx];
    end else begin
      bus_data <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lu_data <= '0;
    end else if (int'(lu_idx) < ENTRIES) begin
      lu_data <= store[lu_idx];
    end else begin
      lu_data <= '0;
    end
  end
endmodule

/* File: hdl/dscp_priority_map_upper.sv */
/*
  Upper DSCP to priority map: twelve byte registers on Avalon-MM,
  each holding the priorities of one even/odd code point pair, plus
  a pipelined lookup port for the frame classifier.
  Assumes a 100 MHz clock, a synchronous active-low reset, a master
  that holds its request until waitrequest is sampled low, and a
  classifier that presents at most one code point per cycle.
*/
`timescale 1ns/100ps
module dscp_priority_map_upper
  import dscp_map_pkg::*;
#(
  parameter int ADDR_W = BUS_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire lookup_req_s       lookup_req,
  output lookup_rsp_s            lookup_rsp
);
  bus_state_e                        state_reg;
  bus_state_e                        state_next;
  reg_decode_s                       dec;
  logic [MAP_IDX_W-1:0]              dec_idx;
  logic                              wr_commit;
  map_entry_s                        wr_entry;
  map_entry_s                        bus_entry;
  map_entry_s                        lu_entry;
  map_entry_s                        sel_entry;
  logic [MAP_ENTRIES*ENTRY_W-1:0]    table_flat;
  logic                              lu_hit;
  logic [MAP_IDX_W-1:0]              lu_idx;
  logic [5:0]                        lu_pair;
  logic                              s1_valid_reg;
  logic                              s1_hit_reg;
  logic                              s1_odd_reg;

  // register index to entry; misaligned or unknown addresses miss
  function automatic reg_decode_s decode(input logic [ADDR_W-1:0] a);
    reg_decode_s d;
    d = '0;
    if (a[1:0] == 2'b00) begin
      d.hit = 1'b1;
      case (a[11:2])
        OFS_MAP_26_27:     d.idx = 4'h0;
        OFS_MAP_28_29:     d.idx = 4'h1;
        OFS_MAP_2A_2B:     d.idx = 4'h2;
        OFS_MAP_2C_2D:     d.idx = 4'h3;
        OFS_MAP_2C_2D_SEQ: d.idx = 4'h3;
        OFS_MAP_2E_2F:     d.idx = 4'h4;
        OFS_MAP_30_31:     d.idx = 4'h5;
        OFS_MAP_32_33:     d.idx = 4'h6;
        OFS_MAP_34_35:     d.idx = 4'h7;
        OFS_MAP_36_37:     d.idx = 4'h8;
        OFS_MAP_38_39:     d.idx = 4'h9;
        OFS_MAP_3A_3B:     d.idx = 4'ha;
        OFS_MAP_3C_3D:     d.idx = 4'hb;
        default:           d.hit = 1'b0;
      endcase
    end
    return d;
  endfunction

  // reserved positions are never filled, so they read zero
  function automatic logic [7:0] pack_entry(input map_entry_s e);
    logic [7:0] b;
    b = MAP_RESET;
    b[PRI_ODD_LSB +: PRI_W]  = e.odd_pri;
    b[PRI_EVEN_LSB +: PRI_W] = e.even_pri;
    return b;
  endfunction

  always_comb begin
    dec       = decode(address);
    dec_idx   = dec.idx;
    sel_entry = map_entry_s'(table_flat[dec_idx*ENTRY_W +: ENTRY_W]);
  end

  // three-step handshake: take, fetch, answer with waitrequest low
  always_comb begin
    case (state_reg)
      BUS_IDLE: begin
        state_next = (read || write) ? BUS_FETCH : BUS_IDLE;
      end
      BUS_FETCH:  state_next = BUS_ANSWER;
      BUS_ANSWER: state_next = BUS_IDLE;
      default:    state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= (state_reg != BUS_FETCH);
    end
  end

  // unmapped reads answer zero, writes to them are dropped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata <= '0;
    end else if (state_reg == BUS_FETCH) begin
      readdata <= '0;
      if (dec.hit) begin
        readdata[7:0] <= pack_entry(bus_entry);
      end
    end
  end

  // write lands at the edge where the master sees waitrequest low;
  // bits 7 and 3 of writedata are simply not stored
  always_comb begin
    wr_commit = (state_reg == BUS_ANSWER) && write && dec.hit &&
                byteenable[0];
    wr_entry.odd_pri  = writedata[PRI_ODD_LSB +: PRI_W];
    wr_entry.even_pri = writedata[PRI_EVEN_LSB +: PRI_W];
  end

  // lookup: entry from code/2 less the first pair, field from parity
  always_comb begin
    lu_hit  = (lookup_req.dscp >= CP_FIRST) &&
              (lookup_req.dscp <= CP_LAST);
    lu_pair = {1'b0, lookup_req.dscp[5:1]} - {1'b0, CP_FIRST[5:1]};
    lu_idx  = lu_hit ? lu_pair[MAP_IDX_W-1:0] : '0;
  end

  pri_map_mem #(
    .ENTRIES (MAP_ENTRIES),
    .IDX_W   (MAP_IDX_W)
  ) u_mem (
    .clk        (clk),
    .reset_n    (reset_n),
    .wr_en      (wr_commit),
    .wr_idx     (dec_idx),
    .wr_data    (wr_entry),
    .bus_idx    (dec_idx),
    .bus_data   (bus_entry),
    .lu_idx     (lu_idx),
    .lu_data    (lu_entry),
    .table_flat (table_flat)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_valid_reg <= 1'b0;
      s1_hit_reg   <= 1'b0;
      s1_odd_reg   <= 1'b0;
    end else begin
      s1_valid_reg <= lookup_req.valid;
      s1_hit_reg   <= lookup_req.valid && lu_hit;
      s1_odd_reg   <= lookup_req.dscp[0];
    end
  end

  // codes outside this table (below 0x26 or above 0x3d) report a miss with priority zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lookup_rsp <= '0;
    end else begin
      lookup_rsp.valid <= s1_valid_reg;
      lookup_rsp.hit   <= s1_hit_reg;
      if (s1_hit_reg) begin
        lookup_rsp.pri <= s1_odd_reg ? lu_entry.odd_pri
                                     : lu_entry.even_pri;
      end else begin
        lookup_rsp.pri <= '0;
      end
    end
  end

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    !waitrequest |-> readdata[31:8] == '0 &&
                     !readdata[RESV_HI_BIT] && !readdata[RESV_LO_BIT])
    else $error("reserved read bits not zero");

  a_wait_timing: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_reg == BUS_IDLE && (read || write)) |->
      waitrequest ##1 waitrequest ##1 !waitrequest ##1 waitrequest)
    else $error("waitrequest not low on third cycle");

  a_read_map: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && dec.hit) |->
      readdata[7:0] == pack_entry(sel_entry))
    else $error("read data differ from addressed entry");

  a_alias_map: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_2C_2D, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[3*ENTRY_W +: ENTRY_W])))
    else $error("0x2c/0x2d entry not at its index");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && !dec.hit) |-> readdata == '0)
    else $error("unmapped read not zero");

  a_write_odd: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && write && dec.hit && byteenable[0]) |=>
      table_flat[$past(dec_idx)*ENTRY_W + PRI_W +: PRI_W] ==
        $past(writedata[6:4]))
    else $error("odd field not stored from bits 6:4");

  a_write_even: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && write && dec.hit && byteenable[0]) |=>
      table_flat[$past(dec_idx)*ENTRY_W +: PRI_W] ==
        $past(writedata[2:0]))
    else $error("even field not stored from bits 2:0");

  a_reset_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(!reset_n) |-> table_flat == '0 && waitrequest &&
                        !lookup_rsp.valid)
    else $error("table or outputs not cleared by reset");

  a_lookup_pri: assert property (
    @(posedge clk) disable iff (!reset_n)
    (lookup_req.valid && lu_hit) |-> ##2 lookup_rsp.valid &&
      lookup_rsp.hit && lookup_rsp.pri == ($past(lookup_req.dscp[0], 2)
        ? $past(lu_entry.odd_pri) : $past(lu_entry.even_pri)))
    else $error("lookup priority not the selected field");

  a_lookup_miss: assert property (
    @(posedge clk) disable iff (!reset_n)
    (lookup_req.valid && !lu_hit) |-> ##2 lookup_rsp.valid &&
      !lookup_rsp.hit && lookup_rsp.pri == '0)
    else $error("miss lookup not reported as miss");

  // each index against a fixed entry, so a decoder slip cannot hide
  a_map_26_27: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_26_27, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[0*ENTRY_W +: ENTRY_W])))
    else $error("index 0x353 not served by entry 0");

  a_map_28_29: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_28_29, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[1*ENTRY_W +: ENTRY_W])))
    else $error("index 0x354 not served by entry 1");

  a_map_2a_2b: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_2A_2B, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[2*ENTRY_W +: ENTRY_W])))
    else $error("index 0x355 not served by entry 2");

  a_seq_2c_2d: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_2C_2D_SEQ, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[3*ENTRY_W +: ENTRY_W])))
    else $error("index 0x356 not served by entry 3");

  a_map_2e_2f: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_2E_2F, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[4*ENTRY_W +: ENTRY_W])))
    else $error("index 0x357 not served by entry 4");

  a_map_30_31: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_30_31, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[5*ENTRY_W +: ENTRY_W])))
    else $error("index 0x358 not served by entry 5");

  a_map_32_33: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_32_33, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[6*ENTRY_W +: ENTRY_W])))
    else $error("index 0x359 not served by entry 6");

  a_map_34_35: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_34_35, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[7*ENTRY_W +: ENTRY_W])))
    else $error("index 0x35a not served by entry 7");

  a_map_36_37: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_36_37, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[8*ENTRY_W +: ENTRY_W])))
    else $error("index 0x35b not served by entry 8");

  a_map_38_39: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_38_39, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[9*ENTRY_W +: ENTRY_W])))
    else $error("index 0x35c not served by entry 9");

  a_map_3a_3b: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_3A_3B, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[10*ENTRY_W +: ENTRY_W])))
    else $error("index 0x35d not served by entry 10");

  a_map_3c_3d: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && read && address == {OFS_MAP_3C_3D, 2'b00}) |->
      readdata[7:0] == pack_entry(map_entry_s'(
        table_flat[11*ENTRY_W +: ENTRY_W])))
    else $error("index 0x35e not served by entry 11");

  a_lane0_drop: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && write && !byteenable[0]) |=> $stable(table_flat))
    else $error("write without lane 0 changed the table");

  a_miss_drop: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!waitrequest && write && !dec.hit) |=> $stable(table_flat))
    else $error("write to unmapped index changed the table");
endmodule

/* File: dv/dscp_priority_map_upper_tb.sv */
/*
  Self-checking bench for the upper DSCP priority map: Avalon-MM
  register accesses plus lookup port checks against a local mirror.
  Assumes the package dscp_map_pkg and the block's hand-over timing.
*/
`timescale 1ns/100ps
`define CHECK(name, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("[ERR] %s exp %h got %h", name, exp, got); \
  end \
end
module dscp_priority_map_upper_tb;
  import dscp_map_pkg::*;
  logic        clk         = 1'b0;
  logic        reset_n     = 1'b0;
  logic [11:0] address     = 12'h000;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0000_0000;
  logic [3:0]  byteenable  = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  lookup_req_s lookup_req  = '0;
  lookup_rsp_s lookup_rsp;
  logic [7:0]  mirror [12];
  int          err_total    = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  // entry k serves code points 0x26 + 2k and 0x27 + 2k
  localparam logic [9:0] idx_tab [12] = '{
    OFS_MAP_26_27, OFS_MAP_28_29, OFS_MAP_2A_2B, OFS_MAP_2C_2D,
    OFS_MAP_2E_2F, OFS_MAP_30_31, OFS_MAP_32_33, OFS_MAP_34_35,
    OFS_MAP_36_37, OFS_MAP_38_39, OFS_MAP_3A_3B, OFS_MAP_3C_3D};

  always #5 clk = ~clk;

  dscp_priority_map_upper u_dscp_priority_map_upper (
    .clk         (clk),
    .reset_n     (reset_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .lookup_req  (lookup_req),
    .lookup_rsp  (lookup_rsp)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard; the full run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("[ERR] run_length exp done got hang");
      print_verdict();
    end
  end

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 12; k++) mirror[k] = MAP_RESET;
  endtask

  // request held until waitrequest is sampled low at a rising edge;
  // only the run's hang guard ends a wait that never answers
  task automatic bus_xfer(input logic wr, input logic [9:0] idx,
                          input logic [7:0] d, input logic [3:0] be,
                          output logic [31:0] rd);
    @(posedge clk);
    address    <= {idx, 2'b00};
    read       <= ~wr;
    write      <= wr;
    writedata  <= {24'ha5a5a5, d};
    byteenable <= be;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr8(input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    logic [31:0] rd;
    bus_xfer(1'b1, idx, d, be, rd);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus_xfer(1'b0, idx, 8'h00, 4'hf, rd);
    `CHECK("readdata", {24'h000000, exp}, rd)
  endtask

  function automatic logic [2:0] exp_pri(input int c);
    logic [7:0] m;
    m = mirror[c / 2 - 'h13];
    return c[0] ? m[6:4] : m[2:0];
  endfunction

  // response looked at in the one cycle it stands, then must drop
  task automatic lookup_chk(input logic [5:0] cp, input logic hit,
                            input logic [2:0] pri);
    @(posedge clk);
    lookup_req <= '{valid: 1'b1, dscp: cp};
    @(posedge clk);
    lookup_req <= '0;
    @(posedge clk);
    @(posedge clk);
    `CHECK("lookup_rsp", {1'b1, hit, pri}, lookup_rsp)
    @(posedge clk);
    `CHECK("lookup_rsp.valid", 1'b0, lookup_rsp.valid)
  endtask

  initial begin
    do_reset();
    for (int k = 0; k < 12; k++) rd_chk(idx_tab[k], 8'h00);
    rd_chk(OFS_MAP_2C_2D_SEQ, 8'h00);
    for (int c = 'h26; c <= 'h3d; c++) lookup_chk(6'(c), 1'b1, 3'h0);
    $display("test reset_values done");

    // reserved bits written as one so a leak shows up
    for (int k = 0; k < 12; k++) begin
      mirror[k] = {1'b0, 3'(k), 1'b0, 3'(k + 3)};
      wr8(idx_tab[k], mirror[k] | 8'h88, 4'hf);
    end
    for (int k = 0; k < 12; k++) begin
      rd_chk(idx_tab[k], mirror[k]);
      rd_chk(idx_tab[k], mirror[k]);
    end
    $display("test field_layout done");

    for (int c = 'h26; c <= 'h3d; c++)
      lookup_chk(6'(c), 1'b1, exp_pri(c));
    lookup_chk(6'h25, 1'b0, 3'h0);
    lookup_chk(6'h3e, 1'b0, 3'h0);
    lookup_chk(6'h3f, 1'b0, 3'h0);
    $display("test lookup done");

    mirror[3] = 8'h52;
    wr8(OFS_MAP_2C_2D_SEQ, 8'h52, 4'h1);
    rd_chk(OFS_MAP_2C_2D, 8'h52);
    lookup_chk(6'h2d, 1'b1, 3'h5);
    lookup_chk(6'h2c, 1'b1, 3'h2);
    wr8(idx_tab[0], 8'h11, 4'he);
    wr8(10'h352, 8'h33, 4'hf);
    rd_chk(10'h352, 8'h00);
    for (int k = 0; k < 12; k++) rd_chk(idx_tab[k], mirror[k]);
    $display("test refusals done");

    do_reset();
    for (int k = 0; k < 12; k++) rd_chk(idx_tab[k], 8'h00);
    lookup_chk(6'h3d, 1'b1, 3'h0);
    $display("test second_reset done");
    print_verdict();
  end
endmodule
